/* hw/crv_remap_regs.svh */
// register indices, field positions and reset values of the remap and routing stage
`ifndef CRV_REMAP_REGS_SVH
`define CRV_REMAP_REGS_SVH
// register indices; the byte address is four times the index
`define CRV_IDX_MATCH15    14'h04ab
`define CRV_IDX_REPLACE15  14'h04ac
`define CRV_IDX_ROUTE0     14'h04ad
`define CRV_IDX_ROUTE1     14'h04ae
`define CRV_IDX_ROUTE2     14'h04af
`define CRV_IDX_ROUTE3     14'h04b0
`define CRV_IDX_CONCAT     14'h04b1
`define CRV_IDX_DESKEW     14'h04b2
`define CRV_IDX_LAYOUT     14'h04b3
`define CRV_IDX_EN_LOW     14'h04cb
`define CRV_IDX_EN_HIGH    14'h04cc
// match and replace byte layout
`define CRV_PAIR_VC_LSB    6
`define CRV_PAIR_DT_LSB    0
// concatenation control layout
`define CRV_CONCAT_SEL_LSB 0
`define CRV_CONCAT_MST_LSB 4
`define CRV_CONCAT_JOIN    7
// deskew select layout
`define CRV_DESKEW_ONE     7
`define CRV_DESKEW_VC_LSB  0
`define CRV_DESKEW_VC_TOP  4
// pixel layout control bits
`define CRV_LAYOUT_ALT12   0
`define CRV_LAYOUT_ALT8    1
`define CRV_LAYOUT_ALT10   2
`define CRV_LAYOUT_UDP24   3
`define CRV_LAYOUT_ALT8B   4
`define CRV_LAYOUT_MASK    8'h1f
// reset value of every control byte
`define CRV_RESET_BYTE     8'h00
`endif

/* hw/crv_pkg.sv */
// types shared by the remap and routing stage
package crv_pkg;
  typedef logic [1:0] crv_vc_t;    // virtual channel of a packet
  typedef logic [5:0] crv_dt_t;    // data type of a packet
  typedef logic [1:0] crv_ctrl_t;  // csi-2 controller number
  typedef logic [7:0] crv_byte_t;  // one control byte
  typedef enum logic {
    CRV_JOIN_STACKED = 1'b0,       // four times the height
    CRV_JOIN_SIDE    = 1'b1        // four times the width
  } crv_join_e;
endpackage : crv_pkg

/* hw/crv_pair_buffer.sv */
// small shift buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module crv_pair_buffer #(
  parameter int unsigned WIDTH = 11,  // bits per word
  parameter int unsigned DEPTH = 2    // words held
) (
  input  wire logic             clock,     // system clock
  input  wire logic             rst_b,     // sync reset, active low
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word in
  output logic                  out_valid, // head word present
  input  wire logic             out_ready, // receiver takes head
  output logic [WIDTH-1:0]      out_data   // head word
);
  logic [WIDTH-1:0] data_reg  [DEPTH];  // slot 0 is the head
  logic [WIDTH-1:0] data_next [DEPTH];
  logic [DEPTH-1:0] valid_reg;          // slot occupancy
  logic [DEPTH-1:0] valid_next;
  logic             ready_reg;          // registered room flag
  logic             ready_next;
  logic             push;
  logic             pop;
  logic             placed;

  // shift on pop, then fill the lowest free slot
  always_comb begin
    pop        = valid_reg[0] & out_ready;
    push       = in_valid & ready_reg;
    valid_next = valid_reg;
    data_next  = data_reg;
    placed     = 1'b0;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        valid_next[i] = valid_reg[i+1];
        data_next[i]  = data_reg[i+1];
      end
      valid_next[DEPTH-1] = 1'b0;
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!valid_next[i] && !placed) begin
          valid_next[i] = 1'b1;
          data_next[i]  = in_data;
          placed        = 1'b1;
        end
      end
    end
    // ready is a flop, so a full buffer cannot take a word in the pop cycle
    ready_next = ~valid_next[DEPTH-1];
  end

  // registers only
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      valid_reg <= '0;
      ready_reg <= 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
        data_reg[i] <= '0;
      end
    end else begin
      valid_reg <= valid_next;
      ready_reg <= ready_next;
      data_reg  <= data_next;
    end
  end

  assign in_ready  = ready_reg;
  assign out_valid = valid_reg[0];
  assign out_data  = data_reg[0];
endmodule : crv_pair_buffer
`default_nettype wire

/* hw/crv_remap_route_top.sv */
// remap, routing and stream control stage with its apb register file
// Notes on behaviour
// - entry 15 source byte is vc/dt match
// - entry 15 destination byte is replacement pair
// - two-bit route code picks controller 0-3
// - four route codes per byte, four bytes
// - low nibble bits select concatenated streams
// - bits 5:4 master first, others ascending
// - bit 7 side by side, else stacked
// - deskew bit 7 low means all channels
// - bits 4:0 pick the single deskew channel
// - layout bits pick alternate pixel layouts
// - bit 3 packs 8-bit udp into 24-bit
// - all controls reset zero, read back
// - enable bit k gates entry k
// - high enable byte gates entries 8-15
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "crv_remap_regs.svh"
module crv_remap_route_top
  import crv_pkg::*;
#(
  parameter int unsigned ADDR_W    = 16, // apb address width
  parameter int unsigned BUF_DEPTH = 2   // output buffer words
) (
  input  wire logic        clock,             // 100 mhz system clock
  input  wire logic        rst_b,             // sync reset, active low
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb access phase
  input  wire logic        pwrite,            // apb direction
  input  wire logic [ADDR_W-1:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  input  wire logic [3:0]  pstrb,             // apb byte strobes
  output logic [31:0]      prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error
  input  wire logic        frame_start,       // pulse between frames
  input  wire logic        pkt_valid,         // packet header offered
  output logic             pkt_ready,         // header taken
  input  wire crv_vc_t     pkt_vc,            // incoming virtual channel
  input  wire crv_dt_t     pkt_dt,            // incoming data type
  input  wire crv_ctrl_t   pkt_default_ctrl,  // controller if unmatched
  input  wire logic [14:0] low_entry_hit,     // matches of entries 0-14
  input  wire logic [119:0] low_entry_replace,// pairs of entries 0-14
  output logic             out_valid,         // routed header valid
  input  wire logic        out_ready,         // receiver ready
  output crv_vc_t          out_vc,            // outgoing virtual channel
  output crv_dt_t          out_dt,            // outgoing data type
  output crv_ctrl_t        out_ctrl,          // chosen controller
  output logic             out_remapped,      // an entry applied
  output logic [3:0]       concat_stream_mask,// streams joined
  output logic [1:0]       concat_master,     // first stream of a line
  output logic [7:0]       concat_order,      // slot 0 in low bits
  output crv_join_e        concat_join,       // side by side or stacked
  output logic [15:0]      deskew_vc_mask,    // channels that carry deskew
  output logic             alt_layout_twelve_bit,       // 12-bit alternate
  output logic             alt_layout_eight_bit,        // 8-bit alternate
  output logic             alt_layout_ten_bit,          // 10-bit alternate
  output logic             second_alt_layout_eight_bit, // 8-bit second alt
  output logic             udp_triple_byte_packing      // 24-bit udp packing
);
  localparam int unsigned PW = 11; // buffered word width

  // live registers written by software
  crv_byte_t   remap_match_entry15_reg, remap_match_entry15_next;
  crv_byte_t   remap_replace_entry15_reg, remap_replace_entry15_next;
  logic [31:0] route_select_reg, route_select_next;   // four route bytes
  crv_byte_t   stream_concat_control_reg, stream_concat_control_next;
  crv_byte_t   deskew_channel_select_reg, deskew_channel_select_next;
  crv_byte_t   pixel_layout_control_reg, pixel_layout_control_next;
  logic [15:0] remap_enable_reg, remap_enable_next;   // high and low bytes
  // apb answer registers
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  // decode helpers
  logic [13:0] idx;        // register index of the address
  logic        mapped;     // address hits a register
  logic        wr_fire;    // completing write
  crv_byte_t   rd_byte;    // read mux

  // apb decode and read mux
  always_comb begin
    idx     = paddr[15:2];
    mapped  = (paddr[1:0] == 2'b00);
    rd_byte = `CRV_RESET_BYTE;
    case (idx)
      `CRV_IDX_MATCH15:   rd_byte = remap_match_entry15_reg;
      `CRV_IDX_REPLACE15: rd_byte = remap_replace_entry15_reg;
      `CRV_IDX_ROUTE0:    rd_byte = route_select_reg[7:0];
      `CRV_IDX_ROUTE1:    rd_byte = route_select_reg[15:8];
      `CRV_IDX_ROUTE2:    rd_byte = route_select_reg[23:16];
      `CRV_IDX_ROUTE3:    rd_byte = route_select_reg[31:24];
      `CRV_IDX_CONCAT:    rd_byte = stream_concat_control_reg;
      `CRV_IDX_DESKEW:    rd_byte = deskew_channel_select_reg;
      `CRV_IDX_LAYOUT:    rd_byte = pixel_layout_control_reg;
      `CRV_IDX_EN_LOW:    rd_byte = remap_enable_reg[7:0];
      `CRV_IDX_EN_HIGH:   rd_byte = remap_enable_reg[15:8];
      default:            mapped  = 1'b0; // unmapped answers with error
    endcase
    wr_fire = psel & penable & pready_reg & pwrite & pstrb[0] & mapped;
  end

  // apb answer: zero wait states, ready in the first access cycle
  always_comb begin
    pready_next  = psel & ~penable;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      // setup cycle: latch the answer for the access cycle
      prdata_next  = {24'h000000, rd_byte};
      pslverr_next = ~mapped;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // register writes take effect only at the completing edge
  always_comb begin
    remap_match_entry15_next   = remap_match_entry15_reg;
    remap_replace_entry15_next = remap_replace_entry15_reg;
    route_select_next          = route_select_reg;
    stream_concat_control_next = stream_concat_control_reg;
    deskew_channel_select_next = deskew_channel_select_reg;
    pixel_layout_control_next  = pixel_layout_control_reg;
    remap_enable_next          = remap_enable_reg;
    if (wr_fire) begin
      case (idx)
        `CRV_IDX_MATCH15:   remap_match_entry15_next = pwdata[7:0];
        `CRV_IDX_REPLACE15: remap_replace_entry15_next = pwdata[7:0];
        `CRV_IDX_ROUTE0:    route_select_next[7:0] = pwdata[7:0];
        `CRV_IDX_ROUTE1:    route_select_next[15:8] = pwdata[7:0];
        `CRV_IDX_ROUTE2:    route_select_next[23:16] = pwdata[7:0];
        `CRV_IDX_ROUTE3:    route_select_next[31:24] = pwdata[7:0];
        `CRV_IDX_CONCAT:    stream_concat_control_next = pwdata[7:0];
        `CRV_IDX_DESKEW:    deskew_channel_select_next = pwdata[7:0];
        // unused layout bits stay zero
        `CRV_IDX_LAYOUT:    pixel_layout_control_next = pwdata[7:0] & `CRV_LAYOUT_MASK;
        `CRV_IDX_EN_LOW:    remap_enable_next[7:0] = pwdata[7:0];
        `CRV_IDX_EN_HIGH:   remap_enable_next[15:8] = pwdata[7:0];
        default:            remap_enable_next = remap_enable_reg;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      remap_match_entry15_reg   <= `CRV_RESET_BYTE;
      remap_replace_entry15_reg <= `CRV_RESET_BYTE;
      route_select_reg          <= {4{`CRV_RESET_BYTE}};
      stream_concat_control_reg <= `CRV_RESET_BYTE;
      deskew_channel_select_reg <= `CRV_RESET_BYTE;
      pixel_layout_control_reg  <= `CRV_RESET_BYTE;
      remap_enable_reg          <= {2{`CRV_RESET_BYTE}};
    end else begin
      remap_match_entry15_reg   <= remap_match_entry15_next;
      remap_replace_entry15_reg <= remap_replace_entry15_next;
      route_select_reg          <= route_select_next;
      stream_concat_control_reg <= stream_concat_control_next;
      deskew_channel_select_reg <= deskew_channel_select_next;
      pixel_layout_control_reg  <= pixel_layout_control_next;
      remap_enable_reg          <= remap_enable_next;
    end
  end

  // shadow table used by the packet path
  crv_byte_t   match_sh_reg, match_sh_next;
  crv_byte_t   replace_sh_reg, replace_sh_next;
  logic [31:0] route_sh_reg, route_sh_next;
  logic [15:0] enable_sh_reg, enable_sh_next;

  // copy only between frames so a frame never sees a half-written table
  always_comb begin
    match_sh_next   = match_sh_reg;
    replace_sh_next = replace_sh_reg;
    route_sh_next   = route_sh_reg;
    enable_sh_next  = enable_sh_reg;
    if (frame_start) begin
      match_sh_next   = remap_match_entry15_reg;
      replace_sh_next = remap_replace_entry15_reg;
      route_sh_next   = route_select_reg;
      enable_sh_next  = remap_enable_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      match_sh_reg   <= `CRV_RESET_BYTE;
      replace_sh_reg <= `CRV_RESET_BYTE;
      route_sh_reg   <= {4{`CRV_RESET_BYTE}};
      enable_sh_reg  <= {2{`CRV_RESET_BYTE}};
    end else begin
      match_sh_reg   <= match_sh_next;
      replace_sh_reg <= replace_sh_next;
      route_sh_reg   <= route_sh_next;
      enable_sh_reg  <= enable_sh_next;
    end
  end

  // match, replace and route one packet header
  logic      low_any;   // an enabled lower entry matched
  logic [3:0] low_idx;  // lowest such entry
  logic      hit15;     // entry 15 matched and enabled
  crv_byte_t low_pair;  // replacement of the lower entry
  crv_vc_t   new_vc;
  crv_dt_t   new_dt;
  crv_ctrl_t new_ctrl;
  logic      remapped;
  logic      push_ready;

  always_comb begin
    low_any = 1'b0;
    low_idx = 4'h0;
    // scan downward so the lowest enabled match is kept
    for (int i = 14; i >= 0; i--) begin
      if (low_entry_hit[i] && enable_sh_reg[i]) begin
        low_any = 1'b1;
        low_idx = 4'(i);
      end
    end
    low_pair = low_entry_replace[8*low_idx +: 8];
    hit15 = enable_sh_reg[15]
         && (pkt_vc == match_sh_reg[`CRV_PAIR_VC_LSB +: 2])
         && (pkt_dt == match_sh_reg[`CRV_PAIR_DT_LSB +: 6]);
    new_vc   = pkt_vc;
    new_dt   = pkt_dt;
    new_ctrl = pkt_default_ctrl; // unmatched packets keep their controller
    remapped = 1'b0;
    if (low_any) begin
      new_vc   = low_pair[`CRV_PAIR_VC_LSB +: 2];
      new_dt   = low_pair[`CRV_PAIR_DT_LSB +: 6];
      new_ctrl = route_sh_reg[2*low_idx +: 2];
      remapped = 1'b1;
    end else if (hit15) begin
      new_vc   = replace_sh_reg[`CRV_PAIR_VC_LSB +: 2];
      new_dt   = replace_sh_reg[`CRV_PAIR_DT_LSB +: 6];
      new_ctrl = route_sh_reg[31:30];
      remapped = 1'b1;
    end
  end

  // one word per packet; a stalled receiver backs up to pkt_ready
  crv_pair_buffer #(
    .WIDTH (PW),
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (pkt_valid),
    .in_ready  (push_ready),
    .in_data   ({remapped, new_ctrl, new_vc, new_dt}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  ({out_remapped, out_ctrl, out_vc, out_dt})
  );

  // registered stream control outputs
  logic [3:0]  mask_reg, mask_next;
  logic [1:0]  master_reg, master_next;
  logic [7:0]  order_reg, order_next;
  crv_join_e   join_reg, join_next;
  logic [15:0] deskew_reg, deskew_next;
  logic [4:0]  layout_reg, layout_next;
  int          slot;

  always_comb begin
    slot        = 1;
    mask_next   = stream_concat_control_reg[`CRV_CONCAT_SEL_LSB +: 4];
    master_next = stream_concat_control_reg[`CRV_CONCAT_MST_LSB +: 2];
    join_next   = crv_join_e'(stream_concat_control_reg[`CRV_CONCAT_JOIN]);
    order_next  = {6'h00, master_next};
    for (int s = 0; s < 4; s++) begin
      if (2'(s) != master_next) begin
        order_next[2*slot +: 2] = 2'(s);
        slot = slot + 1;
      end
    end
    if (!deskew_channel_select_reg[`CRV_DESKEW_ONE]) begin
      deskew_next = 16'hffff;
    end else if (!deskew_channel_select_reg[`CRV_DESKEW_VC_TOP]) begin
      deskew_next = 16'h0001 << deskew_channel_select_reg[3:0];
    end else begin
      deskew_next = 16'h0000; // channel numbers above 15 select nothing
    end
    layout_next = pixel_layout_control_reg[4:0];
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mask_reg   <= 4'h0;
      master_reg <= 2'h0;
      order_reg  <= 8'he4;
      join_reg   <= CRV_JOIN_STACKED;
      deskew_reg <= 16'hffff;
      layout_reg <= 5'h00;
    end else begin
      mask_reg   <= mask_next;
      master_reg <= master_next;
      order_reg  <= order_next;
      join_reg   <= join_next;
      deskew_reg <= deskew_next;
      layout_reg <= layout_next;
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign pkt_ready = push_ready;
  assign concat_stream_mask = mask_reg;
  assign concat_master      = master_reg;
  assign concat_order       = order_reg;
  assign concat_join        = join_reg;
  assign deskew_vc_mask     = deskew_reg;
  assign alt_layout_twelve_bit       = layout_reg[`CRV_LAYOUT_ALT12];
  assign alt_layout_eight_bit        = layout_reg[`CRV_LAYOUT_ALT8];
  assign alt_layout_ten_bit          = layout_reg[`CRV_LAYOUT_ALT10];
  assign udp_triple_byte_packing     = layout_reg[`CRV_LAYOUT_UDP24];
  assign second_alt_layout_eight_bit = layout_reg[`CRV_LAYOUT_ALT8B];

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic push;
  assign push = pkt_valid & push_ready;

  sequence seq_only15;
    push && hit15 && !low_any;
  endsequence

  remap_match_a: assert property (seq_only15 |-> remapped && new_vc == replace_sh_reg[7:6])
    else $error("entry 15 match not replaced");
  remap_replace_a: assert property (seq_only15 |-> new_dt == replace_sh_reg[5:0])
    else $error("entry 15 data type not replaced");
  route_code_a: assert property (seq_only15 |-> new_ctrl == route_sh_reg[31:30])
    else $error("entry 15 routed to wrong controller");
  route_pack_a: assert property (push && low_any |-> new_ctrl == route_sh_reg[2*low_idx +: 2])
    else $error("lower entry route field misplaced");
  concat_mask_a: assert property (##1 $changed(stream_concat_control_reg) |=> concat_stream_mask == $past(stream_concat_control_reg[3:0]))
    else $error("concat mask wrong");
  concat_first_a: assert property (concat_order[1:0] == concat_master)
    else $error("master not first");
  join_mode_a: assert property (##1 1'b1 |-> concat_join == crv_join_e'($past(stream_concat_control_reg[7])))
    else $error("join mode wrong");
  deskew_all_a: assert property (##1 !$past(deskew_channel_select_reg[7]) |-> deskew_vc_mask == 16'hffff)
    else $error("deskew not on all channels");
  deskew_one_a: assert property (##1 $past(deskew_channel_select_reg[7:4]) == 4'h8 |-> $countones(deskew_vc_mask) == 1)
    else $error("single deskew channel wrong");
  layout_bits_a: assert property (##1 udp_triple_byte_packing == $past(pixel_layout_control_reg[3]))
    else $error("udp packing flag wrong");
  reset_zero_a: assert property (disable iff (1'b0) !rst_b |=> route_select_reg == 32'h0 && remap_enable_reg == 16'h0)
    else $error("controls not zero after reset");
  enable_gate_a: assert property (push && !enable_sh_reg[15] && !low_any |-> !remapped && new_ctrl == pkt_default_ctrl)
    else $error("disabled entry applied");
  lowest_wins_a: assert property (push && low_any && hit15 |-> new_vc == low_pair[7:6])
    else $error("entry 15 beat a lower entry");
  shadow_hold_a: assert property (!frame_start |=> $stable(enable_sh_reg) && $stable(route_sh_reg))
    else $error("table changed inside a frame");
endmodule : crv_remap_route_top
`default_nettype wire

/* tb/crv_rx_model.sv */
// downstream receiver model that takes routed headers, promptly or with stalls
`timescale 1ns/100ps
`default_nettype none
module crv_rx_model (
  input  wire logic clock,     // system clock
  input  wire logic rst_b,     // sync reset, active low
  input  wire logic slow,      // stall most cycles when high
  input  wire logic out_valid, // header offered by the stage
  output logic      out_ready  // header taken at an edge where both are high
);
  integer seed = 62567; // fixed stream so runs repeat
  // ready moves only just after an edge; stalls push the buffer to refusal
  always @(posedge clock) begin
    if (!rst_b) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= slow ? (($random(seed) & 3) == 0) : 1'b1;
    end
  end
endmodule : crv_rx_model
`default_nettype wire

/* tb/tb.sv */
// self-checking bench of the remap and routing stage against a queue model
`timescale 1ns/100ps
`default_nettype none
`include "crv_remap_regs.svh"
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h want %h", $time, g, w); end end
module tb;
  import crv_pkg::*;
  logic clock, rst_b, psel, penable, pwrite, frame_start, pkt_valid, slow; // driven here
  logic [15:0]  paddr;             // apb byte address
  logic [31:0]  pwdata, prdata;    // apb data
  logic pready, pslverr, pkt_ready, out_valid, out_ready, out_remapped; // handshakes
  crv_vc_t      pkt_vc, out_vc;    // channels in and out
  crv_dt_t      pkt_dt, out_dt;    // data types in and out
  crv_ctrl_t    pkt_default_ctrl, out_ctrl; // controllers
  logic [14:0]  low_entry_hit;     // outside matches of entries 0-14
  logic [119:0] low_entry_replace; // outside pairs of entries 0-14
  logic [3:0]   concat_stream_mask; // joined streams
  logic [1:0]   concat_master;     // first stream
  logic [7:0]   concat_order;      // slot order
  crv_join_e    concat_join;       // join shape
  logic [15:0]  deskew_vc_mask;    // deskew channels
  logic alt_layout_twelve_bit, alt_layout_eight_bit, alt_layout_ten_bit; // layouts
  logic second_alt_layout_eight_bit, udp_triple_byte_packing; // layouts
  integer seed = 62567, n_mismatch = 0, n_compared = 0; // stimulus and tallies
  logic [13:0]  idx [11] = '{`CRV_IDX_MATCH15, `CRV_IDX_REPLACE15, `CRV_IDX_ROUTE0,
    `CRV_IDX_ROUTE1, `CRV_IDX_ROUTE2, `CRV_IDX_ROUTE3, `CRV_IDX_CONCAT, `CRV_IDX_DESKEW,
    `CRV_IDX_LAYOUT, `CRV_IDX_EN_LOW, `CRV_IDX_EN_HIGH}; // register indices
  logic [7:0]   mirror [11] = '{default: 8'h00}; // live register model
  logic [7:0]   shadow [11] = '{default: 8'h00}; // table in force this frame
  logic [10:0]  exp_q [$];         // expected headers in order
  logic [10:0]  exp_x;             // expectation of the header just offered
  logic [7:0]   r;                 // read byte
  logic         e;                 // error flag
  crv_remap_route_top uut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .frame_start, .pkt_valid, .pkt_ready,
    .pkt_vc, .pkt_dt, .pkt_default_ctrl, .low_entry_hit, .low_entry_replace, .out_valid,
    .out_ready, .out_vc, .out_dt, .out_ctrl, .out_remapped, .concat_stream_mask,
    .concat_master, .concat_order, .concat_join, .deskew_vc_mask, .alt_layout_twelve_bit,
    .alt_layout_eight_bit, .alt_layout_ten_bit, .second_alt_layout_eight_bit,
    .udp_triple_byte_packing);
  crv_rx_model rx (.clock, .rst_b, .slow, .out_valid, .out_ready);
  // free-running 100 mhz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // one apb transfer; an idle cycle after it so no signal is set twice in a step
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] rd_b, output logic er);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    t = 0;
    do begin @(posedge clock); t++; end while (pready !== 1'b1 && t < 50);
    if (t >= 50) n_mismatch++;
    rd_b = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic wr(int i, logic [7:0] d);
    apb(1'b1, {idx[i], 2'b00}, d, r, e);
    mirror[i] = d & ((i == 8) ? `CRV_LAYOUT_MASK : 8'hff); // upper layout bits unused
  endtask : wr
  task automatic rd(int i);
    apb(1'b0, {idx[i], 2'b00}, 8'h00, r, e);
    `CHK({e, r}, {1'b0, mirror[i]})
  endtask : rd
  function automatic logic [7:0] exp_order(input logic [1:0] m);
    int s;
    exp_order = {6'h0, m};
    s = 1;
    for (int k = 0; k < 4; k++) if (k != m) begin
      exp_order[2*s+:2] = 2'(k);
      s++;
    end
  endfunction : exp_order
  // control outputs settle one cycle after the write edge
  task automatic cfg_chk();
    logic [7:0] c, k;
    c = mirror[6];
    k = mirror[7];
    repeat (2) @(posedge clock);
    `CHK({concat_stream_mask, concat_master, concat_join}, {c[3:0], c[5:4], c[7]})
    `CHK(concat_order, exp_order(c[5:4]))
    `CHK(deskew_vc_mask, !k[7] ? 16'hffff : k[4] ? 16'h0 : 16'h1 << k[3:0])
    `CHK({second_alt_layout_eight_bit, udp_triple_byte_packing, alt_layout_ten_bit,
      alt_layout_eight_bit, alt_layout_twelve_bit}, mirror[8][4:0])
  endtask : cfg_chk
  task automatic frame();
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    shadow = mirror;
    @(posedge clock);
  endtask : frame
  // offer n headers; every other one aims at entry 15's match pattern
  task automatic send(int n);
    int k, t;
    logic [9:0] v;
    logic [127:0] rr;
    logic [15:0] en;
    logic [31:0] rt;
    en = {shadow[10], shadow[9]};
    rt = {shadow[5], shadow[4], shadow[3], shadow[2]};
    for (int i = 0; i < n; i++) begin
      v = 10'($random(seed));
      if (i % 2) v[9:2] = shadow[0];
      rr = {$random(seed), $random(seed), $random(seed), $random(seed)};
      {pkt_vc, pkt_dt, pkt_default_ctrl} <= v;
      low_entry_hit <= 15'($random(seed) & $random(seed) & $random(seed));
      low_entry_replace <= rr[119:0];
      pkt_valid <= 1'b1;
      t = 0;
      do begin @(posedge clock); t++; end while (pkt_ready !== 1'b1 && t < 200);
      if (t >= 200) n_mismatch++;
      k = 15;
      for (int j = 14; j >= 0; j--) if (low_entry_hit[j] && en[j]) k = j;
      if (k < 15) exp_x = {1'b1, rt[2*k+:2], low_entry_replace[8*k+:8]};
      else if (en[15] && {pkt_vc, pkt_dt} === shadow[0]) exp_x = {1'b1, rt[31:30], shadow[1]};
      else exp_x = {1'b0, pkt_default_ctrl, pkt_vc, pkt_dt};
      exp_q.push_back(exp_x);
    end
    pkt_valid <= 1'b0;
    t = 0;
    while (exp_q.size() != 0 && t < 800) begin @(posedge clock); t++; end
    `CHK(exp_q.size(), 0)
  endtask : send
  // compare every header the receiver takes
  always @(posedge clock) begin : cmp_out
    logic [10:0] head; // taken once per word
    if (rst_b && out_valid === 1'b1 && out_ready === 1'b1) begin
      head = (exp_q.size() != 0) ? exp_q.pop_front() : 11'bx;
      `CHK({out_remapped, out_ctrl, out_vc, out_dt}, head)
    end
  end
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    #600000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {psel, penable, pwrite, frame_start, pkt_valid, slow, rst_b} = '0;
    {paddr, pwdata, pkt_vc, pkt_dt, pkt_default_ctrl} = '0;
    {low_entry_hit, low_entry_replace} = '0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 11; i++) rd(i);
    cfg_chk();
    $display("test reset done");
    for (int i = 0; i < 11; i++) begin wr(i, 8'($random(seed))); rd(i); end
    apb(1'b0, 16'h1300, 8'h00, r, e);
    `CHK({e, r}, 9'h100)
    apb(1'b1, {`CRV_IDX_CONCAT, 2'b01}, 8'h5a, r, e);
    `CHK(e, 1'b1)
    rd(6);
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      wr(6, 8'($random(seed)));
      wr(7, (i == 0) ? 8'h9f : (i == 1) ? 8'h8f : 8'($random(seed)));
      wr(8, 8'($random(seed)));
      cfg_chk();
    end
    $display("test controls done");
    frame();
    send(40);
    for (int i = 0; i < 6; i++) wr(i, 8'($random(seed)));
    wr(9, 8'($random(seed)));
    wr(10, 8'hff);
    slow <= 1'b1;
    send(40);
    frame();
    send(60);
    $display("test packets done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
